// ---- hdl/fsc_consts.svh ----
`ifndef FSC_CONSTS_SVH
`define FSC_CONSTS_SVH
`define FSC_HOME_POS      4'h0
`define FSC_LAST_POS      4'h9
`define FSC_MULT_FACTOR   4'h3
`define FSC_CLK_PERIOD_NS 25
`define FSC_CLR_HOLD_MS   2000
`define FSC_DATA_WAIT_US  1500
`define FSC_PIN_W         58
`endif

// ---- hdl/fsc_pkg.sv ----
package fsc_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_CYCLE = 3'b010,
    ST_STEP  = 3'b100
  } fsc_state_type;
  typedef enum logic [1:0] {
    CTL_HOLD    = 2'h0,
    CTL_ADVANCE = 2'h1,
    CTL_CLEAR   = 2'h2
  } fsc_ctl_type;
endpackage : fsc_pkg

// ---- hdl/fsc_space_calc.sv ----
`timescale 1ns/1ps
`include "fsc_consts.svh"
module fsc_space_calc
  import fsc_pkg::*;
(
  // Position settings
  input  wire logic        fmt_mode_in,
  input  wire fsc_ctl_type ctl_in,
  input  wire logic [1:0]  space_in,
  input  wire logic        mult_in,
  input  wire logic        stop_paper_in,
  // Result
  output logic [3:0]       spaces_out
);
  always_comb begin
    spaces_out = {2'b00, space_in};
    if (!fmt_mode_in) begin
      if (stop_paper_in) spaces_out = 4'h0;
    end else if (ctl_in != CTL_ADVANCE) begin
      spaces_out = 4'h0;
    end else if (mult_in) begin
      spaces_out = 4'({2'b00, space_in} * `FSC_MULT_FACTOR);
    end else if (stop_paper_in) begin
      spaces_out = 4'h0;
    end
  end
endmodule : fsc_space_calc

// ---- hdl/fsc_format_ctrl.sv ----
`timescale 1ns/1ps
`include "fsc_consts.svh"
module fsc_format_ctrl
  import fsc_pkg::*;
#(
  parameter int unsigned CLR_HOLD_CYCLES  =
    (`FSC_CLR_HOLD_MS * 1000000 + `FSC_CLK_PERIOD_NS - 1) / `FSC_CLK_PERIOD_NS,
  parameter int unsigned DATA_WAIT_CYCLES = `FSC_DATA_WAIT_US * 1000 / `FSC_CLK_PERIOD_NS
) (
  // Clock and reset
  input  wire logic        clock_in,
  input  wire logic        rstn_in,
  // Host commands, same clock
  input  wire logic        external_function_command_in,
  input  wire logic        cmd_start_in,
  input  wire logic        cmd_skip_in,
  input  wire logic        cmd_print_in,
  input  wire logic        cmd_stop_paper_in,
  input  wire logic        external_write_command_in,
  input  wire logic        master_clear_in,
  input  wire logic        clear_a_fault_in,
  // Switchboard and printer pins, asynchronous
  input  wire logic [19:0] sw_control_in,
  input  wire logic [19:0] sw_space_in,
  input  wire logic [9:0]  sw_multiply_in,
  input  wire logic        clear_control_in,
  input  wire logic        paper_low_in,
  input  wire logic        overheat_in,
  input  wire logic        interlock_override_in,
  input  wire logic        local_clear_in,
  input  wire logic        cycle_point_in,
  input  wire logic        cycle_end_in,
  input  wire logic        motion_in,
  // Printer drive
  output logic             cycle_run_out,
  output logic             print_out,
  output logic             space_go_out,
  output logic [3:0]       space_count_out,
  output logic [3:0]       format_pos_out,
  output logic             format_mode_out,
  output logic             printer_stop_out,
  // Faults
  output logic             no_paper_lamp_out,
  output logic             jam_lamp_out,
  output logic             missing_data_lamp_out,
  output logic             overheat_lamp_out,
  output logic             fault_a_out,
  output logic             fault_b_out,
  output logic             host_stop_out
);
  logic [`FSC_PIN_W-1:0] pins_s1_q, pins_s2_q;
  logic [19:0]   sw_ctl, sw_spc;
  logic [9:0]    sw_mul;
  logic          clrctl, paper_low, overheat, override, local_clr, point, cyc_end, motion;
  logic          point_d_q, cyc_end_d_q, local_clr_d_q, point_rise, cyc_end_rise;
  fsc_state_type state_q;
  logic [3:0]    pos_q, next_pos, calc_spaces;
  logic          fmt_q, stop_q, print_q, go_q, motion_seen_q, any_fault, jam_now;
  logic [3:0]    space_q;
  fsc_ctl_type   cur_ctl;
  logic [1:0]    cur_space;
  logic          cur_mult, start_ok;
  logic [26:0]   clr_cnt_q;
  logic          clr_force_q;
  logic [15:0]   wait_cnt_q;
  logic          waiting_q;
  logic          no_paper_q, paper_pend_q, jam_q, missing_q, overheat_q;

  function automatic fsc_ctl_type pos_ctl(input logic [19:0] sw, input logic [3:0] p);
    logic [1:0] c;
    c = sw[{p, 1'b0} +: 2];
    if (p == `FSC_HOME_POS) return CTL_HOLD;
    if (c == CTL_ADVANCE) return CTL_ADVANCE;
    if (c == CTL_CLEAR) return CTL_CLEAR;
    return CTL_HOLD;
  endfunction : pos_ctl

  function automatic logic [3:0] pos_after(input logic [3:0] p);
    return (p == `FSC_LAST_POS) ? `FSC_HOME_POS : 4'(p + 4'h1);
  endfunction : pos_after

  // Two-stage synchroniser for all pins
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pins_s1_q <= '0;
      pins_s2_q <= '0;
    end else begin
      pins_s1_q <= {sw_control_in, sw_space_in, sw_multiply_in, clear_control_in,
                    paper_low_in, overheat_in, interlock_override_in, local_clear_in,
                    cycle_point_in, cycle_end_in, motion_in};
      pins_s2_q <= pins_s1_q;
    end
  end
  assign {sw_ctl, sw_spc, sw_mul, clrctl, paper_low, overheat, override, local_clr,
          point, cyc_end, motion} = pins_s2_q;

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      point_d_q     <= 1'b0;
      cyc_end_d_q   <= 1'b0;
      local_clr_d_q <= 1'b0;
    end else begin
      point_d_q     <= point;
      cyc_end_d_q   <= cyc_end;
      local_clr_d_q <= local_clr;
    end
  end
  assign point_rise   = point && !point_d_q;
  assign cyc_end_rise = cyc_end && !cyc_end_d_q && (state_q == ST_CYCLE);

  assign next_pos  = pos_after(pos_q);
  assign cur_ctl   = pos_ctl(sw_ctl, pos_q);
  assign cur_space = sw_spc[{pos_q, 1'b0} +: 2];
  assign cur_mult  = sw_mul[pos_q];
  assign any_fault = no_paper_q || jam_q || missing_q || overheat_q;
  assign start_ok  = external_function_command_in && cmd_start_in && !any_fault;
  assign jam_now   = (state_q == ST_CYCLE) && motion_seen_q && !motion;

  fsc_space_calc u_calc (
    .fmt_mode_in   (state_q == ST_STEP),
    .ctl_in        (cur_ctl),
    .space_in      (cur_space),
    .mult_in       (cur_mult),
    .stop_paper_in ((state_q == ST_STEP) ? stop_q : cmd_stop_paper_in),
    .spaces_out    (calc_spaces)
  );

  // Sequencer: computer-controlled cycles, format transitions, automatic steps
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_q <= ST_IDLE;
      pos_q   <= `FSC_HOME_POS;
      fmt_q   <= 1'b0;
      stop_q  <= 1'b0;
      print_q <= 1'b0;
      go_q    <= 1'b0;
      space_q <= 4'h0;
    end else begin
      go_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (clr_force_q) begin
            pos_q <= `FSC_HOME_POS;
            fmt_q <= 1'b0;
          end else if (start_ok) begin
            state_q <= ST_CYCLE;
            go_q    <= 1'b1;
            space_q <= calc_spaces;
            print_q <= cmd_print_in;
            stop_q  <= cmd_stop_paper_in;
            if (cmd_skip_in && pos_ctl(sw_ctl, next_pos) == CTL_ADVANCE) begin
              pos_q <= next_pos;
              fmt_q <= 1'b1;
            end
          end
        end
        ST_CYCLE: begin
          if (jam_now) begin
            state_q <= ST_IDLE;
            fmt_q   <= 1'b0;
          end else if (cyc_end_rise) begin
            state_q <= fmt_q ? ST_STEP : ST_IDLE;
            print_q <= 1'b0;
          end
        end
        ST_STEP: begin
          if (clr_force_q || any_fault || cur_ctl == CTL_HOLD) begin
            state_q <= ST_IDLE;
            fmt_q   <= 1'b0;
            if (clr_force_q) pos_q <= `FSC_HOME_POS;
          end else if (cur_ctl == CTL_CLEAR) begin
            pos_q <= next_pos;
          end else begin
            state_q <= ST_CYCLE;
            go_q    <= 1'b1;
            space_q <= calc_spaces;
            pos_q   <= next_pos;
            print_q <= 1'b0;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Clear control hold timer; a short press has no effect
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      clr_cnt_q   <= '0;
      clr_force_q <= 1'b0;
    end else begin
      // Force stands while held, so a press spanning a running cycle still homes
      clr_force_q <= clrctl && (clr_cnt_q >= 27'(CLR_HOLD_CYCLES - 1));
      if (!clrctl) clr_cnt_q <= '0;
      else if (clr_cnt_q != 27'(CLR_HOLD_CYCLES)) clr_cnt_q <= clr_cnt_q + 27'h1;
    end
  end

  // First-field watchdog per cycle point
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      waiting_q  <= 1'b0;
      wait_cnt_q <= '0;
    end else if (point_rise && state_q == ST_CYCLE) begin
      // A field loaded in the cycle the point is seen counts; earlier ones are lost
      waiting_q  <= !external_write_command_in;
      wait_cnt_q <= '0;
    end else if (external_write_command_in || state_q != ST_CYCLE) begin
      waiting_q  <= 1'b0;
    end else if (waiting_q) begin
      wait_cnt_q <= wait_cnt_q + 16'h1;
      if (wait_cnt_q == 16'(DATA_WAIT_CYCLES - 1)) waiting_q <= 1'b0;
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) motion_seen_q <= 1'b0;
    // Cleared outside cycles; go arrives too late to mask the first cycle clock
    else if (state_q != ST_CYCLE) motion_seen_q <= 1'b0;
    else if (motion) motion_seen_q <= 1'b1;
  end

  // Fault flags: a set in the same cycle as a clear wins, except paper_pend_q, where the clear on go wins
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      paper_pend_q <= 1'b0;
      no_paper_q   <= 1'b0;
    end else begin
      if (go_q) paper_pend_q <= 1'b0;
      else if (state_q == ST_CYCLE && paper_low) paper_pend_q <= 1'b1;
      // Deferred to cycle end so lines already loaded still print
      if (cyc_end_rise && (paper_pend_q || paper_low)) no_paper_q <= 1'b1;
      else if (local_clr && !local_clr_d_q) no_paper_q <= 1'b0;
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      jam_q     <= 1'b0;
      missing_q <= 1'b0;
    end else begin
      if (jam_now) jam_q <= 1'b1;
      else if (master_clear_in) jam_q <= 1'b0;
      if (waiting_q && !external_write_command_in && state_q == ST_CYCLE &&
          wait_cnt_q == 16'(DATA_WAIT_CYCLES - 1)) missing_q <= 1'b1;
      else if (master_clear_in) missing_q <= 1'b0;
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) overheat_q <= 1'b0;
    else if (overheat && !override) overheat_q <= 1'b1;
    else if (clear_a_fault_in) overheat_q <= 1'b0;
  end

  // Registered fault reporting to printer and host
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      fault_a_out      <= 1'b0;
      fault_b_out      <= 1'b0;
      host_stop_out    <= 1'b0;
      printer_stop_out <= 1'b0;
    end else begin
      fault_a_out      <= overheat_q;
      fault_b_out      <= jam_q || missing_q;
      host_stop_out    <= any_fault;
      printer_stop_out <= jam_q || ((missing_q || no_paper_q) && state_q != ST_CYCLE);
    end
  end

  assign cycle_run_out         = state_q[1];
  assign print_out             = print_q;
  assign space_go_out          = go_q;
  assign space_count_out       = space_q;
  assign format_pos_out        = pos_q;
  assign format_mode_out       = fmt_q;
  assign no_paper_lamp_out     = no_paper_q;
  assign jam_lamp_out          = jam_q;
  assign missing_data_lamp_out = missing_q;
  assign overheat_lamp_out     = overheat_q;

  // Checks
  logic [3:0] step_run_q;
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) step_run_q <= 4'h0;
    else if (state_q == ST_STEP) step_run_q <= step_run_q + 4'h1;
    else step_run_q <= 4'h0;
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);

  AST_ADV_SPACE: assert property (
    state_q == ST_STEP && cur_ctl == CTL_ADVANCE && !any_fault && !clr_force_q && cur_mult
    |=> space_go_out && space_count_out == 4'({2'b00, $past(cur_space)} * 4'h3)
        && format_pos_out == $past(next_pos))
    else $error("advance spacing wrong");
  AST_CLEAR_STEP: assert property (
    state_q == ST_STEP && cur_ctl == CTL_CLEAR && !any_fault && !clr_force_q
    |=> !space_go_out && format_pos_out == $past(next_pos))
    else $error("clear position moved paper");
  AST_ONE_GO: assert property (
    space_go_out |-> cycle_run_out ##1 !space_go_out)
    else $error("spacing not tied to one cycle");
  AST_CLEAR_RUN: assert property (step_run_q < 4'hB)
    else $error("clear run too long");
  AST_FORCE_HOME: assert property (
    clr_force_q && state_q != ST_CYCLE |=> format_pos_out == 4'h0 && !format_mode_out)
    else $error("clear control ignored");
  AST_STOP_NOMOVE: assert property (
    state_q == ST_STEP && cur_ctl == CTL_ADVANCE && stop_q && !cur_mult && !any_fault
    && !clr_force_q |=> space_go_out && space_count_out == 4'h0)
    else $error("stop paper moved paper");
  AST_PAPER_LATE: assert property (
    $rose(no_paper_lamp_out) |-> $past(cyc_end_rise) ##2 host_stop_out)
    else $error("no paper fault mistimed");
  AST_JAM_STOP: assert property (
    jam_now |=> jam_lamp_out && !cycle_run_out ##1 fault_b_out && printer_stop_out)
    else $error("jam not stopped");
  AST_FINISH_CYCLE: assert property (
    missing_q && state_q == ST_CYCLE && !jam_now && !cyc_end_rise |=> state_q == ST_CYCLE)
    else $error("cycle cut short after missing data");
  AST_OVERHEAT: assert property (
    overheat && !override |=> overheat_lamp_out ##1 fault_a_out && host_stop_out)
    else $error("overheat not stopped");
  AST_NO_START: assert property (
    state_q == ST_IDLE && any_fault |=> !space_go_out)
    else $error("start accepted under fault");

  COV_FMT_RUN: cover property (state_q == ST_STEP ##1 space_go_out);
  COV_CLEAR_HOME: cover property (state_q == ST_STEP && cur_ctl == CTL_CLEAR
                                  ##1 format_pos_out == 4'h0);
  COV_MISSING: cover property ($rose(missing_data_lamp_out));
endmodule : fsc_format_ctrl

// ---- testbench/fsc_host_model.sv ----
`timescale 1ns/1ps
module fsc_host_model (
  // Clock
  input  wire logic       clock_in,
  // Printer side
  input  wire logic       cycle_point_in,
  // Bench control of answer speed
  input  wire logic       answer_en_in,
  input  wire logic [7:0] answer_delay_in,
  // Commands towards the printer
  output logic            efc_out,
  output logic            start_out,
  output logic            skip_out,
  output logic            print_out,
  output logic            stop_out,
  output logic            ewc_out
);
  initial begin
    {efc_out, start_out, skip_out, print_out, stop_out, ewc_out} = 6'h00;
  end
  task automatic send_cmd(input logic skip, input logic print, input logic stop);
    @(posedge clock_in);
    #2;
    {efc_out, start_out, skip_out, print_out, stop_out} = {2'b11, skip, print, stop};
    @(posedge clock_in);
    #2;
    {efc_out, start_out, skip_out, print_out, stop_out} = 5'h00;
  endtask : send_cmd
  // Slow answers still land inside the data window
  always @(posedge cycle_point_in) begin
    if (answer_en_in) begin
      repeat (answer_delay_in) @(posedge clock_in);
      #2;
      ewc_out = 1'b1;
      @(posedge clock_in);
      #2;
      ewc_out = 1'b0;
    end
  end
endmodule : fsc_host_model

// ---- testbench/tb_printer_format_spacing_control.sv ----
`timescale 1ns/1ps
module tb_printer_format_spacing_control;
  import fsc_pkg::*;
  localparam int CLR_HOLD = 20;
  localparam int DATA_WAIT = 16;
  logic        clock_in, rstn_in, efc, c_start, c_skip, c_print, c_stop, ewc;
  logic        master_clear, clear_a, clear_ctl, paper_low, overheat, override;
  logic        local_clear, cyc_point, cyc_end, motion, answer_en;
  logic [7:0]  answer_delay;
  logic [19:0] sw_ctl, sw_sp;
  logic [9:0]  sw_mul;
  logic        run, prn, go, fmode, pstop, lamp_np, lamp_jam, lamp_md, lamp_oh, fa, fb, hstop;
  logic [3:0]  cnt, pos;
  logic [31:0] seed, r;
  int          fails, samples_checked, spos;
  int          exp_q[$];

  fsc_format_ctrl #(.CLR_HOLD_CYCLES(CLR_HOLD), .DATA_WAIT_CYCLES(DATA_WAIT)) i_fsc_format_ctrl (
    .clock_in(clock_in), .rstn_in(rstn_in), .external_function_command_in(efc),
    .cmd_start_in(c_start), .cmd_skip_in(c_skip), .cmd_print_in(c_print),
    .cmd_stop_paper_in(c_stop), .external_write_command_in(ewc),
    .master_clear_in(master_clear), .clear_a_fault_in(clear_a), .sw_control_in(sw_ctl),
    .sw_space_in(sw_sp), .sw_multiply_in(sw_mul), .clear_control_in(clear_ctl),
    .paper_low_in(paper_low), .overheat_in(overheat), .interlock_override_in(override),
    .local_clear_in(local_clear), .cycle_point_in(cyc_point), .cycle_end_in(cyc_end),
    .motion_in(motion), .cycle_run_out(run), .print_out(prn), .space_go_out(go),
    .space_count_out(cnt), .format_pos_out(pos), .format_mode_out(fmode),
    .printer_stop_out(pstop), .no_paper_lamp_out(lamp_np), .jam_lamp_out(lamp_jam),
    .missing_data_lamp_out(lamp_md), .overheat_lamp_out(lamp_oh), .fault_a_out(fa),
    .fault_b_out(fb), .host_stop_out(hstop));

  fsc_host_model i_fsc_host_model (
    .clock_in(clock_in), .cycle_point_in(cyc_point), .answer_en_in(answer_en),
    .answer_delay_in(answer_delay), .efc_out(efc), .start_out(c_start), .skip_out(c_skip),
    .print_out(c_print), .stop_out(c_stop), .ewc_out(ewc));

  initial begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic check(input logic [7:0] seen, input logic [7:0] expv);
    samples_checked++;
    if (seen !== expv) begin
      fails++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, expv);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
    #2;
  endtask : tick

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict

  task automatic wait_go(output bit seen);
    seen = 1'b0;
    for (int k = 0; k < 40 && !seen; k++) begin
      if (go === 1'b1) seen = 1'b1;
      else tick(1);
    end
  endtask : wait_go

  // Motion stays low: a rise then fall would read as a jam
  task automatic do_cycle();
    r = rnd();
    answer_delay = 8'h02 + {4'h0, r[3:0] % 4'hB};
    cyc_point = 1'b1;
    tick(2);
    cyc_point = 1'b0;
    tick(14);
    cyc_end = 1'b1;
    tick(2);
    cyc_end = 1'b0;
  endtask : do_cycle

  task automatic model(input bit skip, input bit stop);
    int c;
    int sp;
    exp_q.push_back(stop ? 0 : int'(sw_sp[2*spos+:2]));
    if (skip && spos != 9 && sw_ctl[2*((spos+1)%10)+:2] == 2'h1) begin
      spos = (spos + 1) % 10;
      while (spos != 0) begin
        c = int'(sw_ctl[2*spos+:2]);
        sp = int'(sw_sp[2*spos+:2]);
        if (c == 0 || c == 3) break;
        if (c == 1) exp_q.push_back(sw_mul[spos] ? 3 * sp : (stop ? 0 : sp));
        spos = (spos + 1) % 10;
      end
    end
  endtask : model

  task automatic run_command(input bit skip, input bit stop);
    bit seen;
    int n;
    model(skip, stop);
    i_fsc_host_model.send_cmd(skip, 1'b0, stop);
    while (exp_q.size() > 0) begin
      wait_go(seen);
      check(8'(seen), 8'h01);
      if (!seen) break;
      check(8'(cnt), 8'(exp_q.pop_front()));
      check(8'(run), 8'h01);
      check(8'(prn), 8'h00);
      do_cycle();
    end
    exp_q.delete();
    n = 0;
    for (int k = 0; k < 14; k++) begin
      if (go === 1'b1) n++;
      tick(1);
    end
    check(8'(n), 8'h00);
    check(8'(pos), 8'(spos));
    check(8'(fmode), 8'h00);
  endtask : run_command

  task automatic one_cmd();
    bit seen;
    i_fsc_host_model.send_cmd(1'b0, 1'b1, 1'b0);
    wait_go(seen);
    check(8'(seen), 8'h01);
    check(8'(prn), 8'h01);
    tick(1);
  endtask : one_cmd

  initial begin
    {rstn_in, master_clear, clear_a, clear_ctl, paper_low, overheat} = 6'h00;
    {override, local_clear, cyc_point, cyc_end, motion} = 5'h00;
    answer_en = 1'b1;
    answer_delay = 8'h03;
    {sw_ctl, sw_sp, sw_mul} = 50'h0;
    seed = 32'h0000000D;
    spos = 0;
    repeat (10) @(posedge clock_in);
    #2;
    rstn_in = 1'b1;
    tick(1);
    check({pos, run, go, fmode, hstop}, 8'h00);
    $display("test reset done");
    for (int t = 0; t < 10; t++) begin
      r = rnd();
      sw_ctl = r[19:0];
      sw_ctl[2*spos+:2] = 2'h0;
      sw_mul = r[29:20];
      r = rnd();
      sw_sp = r[19:0];
      tick(5);
      run_command(t != 3 && r[20], r[21]);
    end
    $display("test random formats done");
    clear_ctl = 1'b1;
    tick(CLR_HOLD + 8);
    clear_ctl = 1'b0;
    spos = 0;
    tick(4);
    check(8'(pos), 8'h00);
    sw_ctl = {{8{2'h2}}, 2'h1, 2'h0};
    tick(5);
    run_command(1'b1, 1'b0);
    $display("test clear run done");
    answer_en = 1'b0;
    i_fsc_host_model.send_cmd(1'b0, 1'b1, 1'b0);
    cyc_point = 1'b1;
    tick(DATA_WAIT + 8);
    check(8'({lamp_md, fb, hstop, run}), 8'h0F);
    cyc_end = 1'b1;
    tick(8);
    check(8'({run, pstop}), 8'h01);
    {cyc_end, cyc_point, answer_en, master_clear} = 4'h3;
    tick(2);
    master_clear = 1'b0;
    tick(4);
    check(8'({lamp_md, fb}), 8'h00);
    $display("test missing data done");
    one_cmd();
    motion = 1'b1;
    tick(5);
    motion = 1'b0;
    tick(6);
    check(8'({lamp_jam, run, fb, pstop, hstop}), 8'h17);
    master_clear = 1'b1;
    tick(2);
    master_clear = 1'b0;
    tick(4);
    check(8'({lamp_jam, fb}), 8'h00);
    $display("test jam done");
    paper_low = 1'b1;
    for (int k = 0; k < 2; k++) begin
      one_cmd();
      tick(4);
      check(8'(lamp_np), 8'h00);
      do_cycle();
      tick(8);
      check(8'({lamp_np, hstop}), 8'h03);
      if (k == 1) paper_low = 1'b0;
      tick(4);
      local_clear = 1'b1;
      tick(5);
      local_clear = 1'b0;
      tick(4);
      check(8'(lamp_np), 8'h00);
    end
    $display("test no paper done");
    overheat = 1'b1;
    tick(8);
    check(8'({lamp_oh, fa, hstop}), 8'h07);
    override = 1'b1;
    tick(5);
    clear_a = 1'b1;
    tick(2);
    clear_a = 1'b0;
    tick(4);
    check(8'({lamp_oh, fa}), 8'h00);
    one_cmd();
    do_cycle();
    {overheat, override} = 2'h0;
    tick(8);
    $display("test overheat done");
    print_verdict();
  end

  initial begin
    repeat (30000) @(posedge clock_in);
    fails++;
    print_verdict();
  end
endmodule : tb_printer_format_spacing_control
